// ---- inc/trc_pkg.sv ----
// constants and carrier types for the reload/capture timer
package trc_pkg;

    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 8;

    // special-function register addresses
    localparam logic [7:0]  ADDR_RELOAD_L = 8'h00ca;
    localparam logic [7:0]  ADDR_RELOAD_H = 8'h00cb;
    localparam logic [7:0]  ADDR_COUNT_L  = 8'h00cc;
    localparam logic [7:0]  ADDR_COUNT_H  = 8'h00cd;

    // reset values and the byte wrap value
    localparam logic [7:0]  RST_BYTE      = 8'h0000;
    localparam logic [7:0]  BYTE_MAX      = 8'h00ff;
    localparam logic [7:0]  READ_UNMAPPED = 8'h0000;

    // clock dividers
    localparam int          SYS_DIV       = 12;
    localparam int          EXT_DIV       = 8;
    localparam int          DIV_W         = 4;
    localparam logic [3:0]  SYS_DIV_LAST  = 4'(SYS_DIV - 1);
    localparam logic [3:0]  EXT_DIV_LAST  = 4'(EXT_DIV - 1);
    localparam logic [3:0]  DIV_ZERO      = 4'h0000;

    // one register access from the core, taken in one cycle
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } trc_sfr_req_t;

    // mode and source controls from the control registers
    typedef struct packed {
        logic split_mode_enable;
        logic run_control;
        logic capture_mode_enable;
        logic external_clock_select;
        logic high_byte_clock_select;
        logic low_byte_clock_select;
    } trc_ctrl_t;

    // overflow flags, clear strobes
    typedef struct packed {
        logic high;
        logic low;
    } trc_flags_t;

endpackage

// ---- hdl/trc_timer.sv ----
// reload/capture timer with clock-source selection and count registers
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - external select 0: timer ticks at system clock divided by twelve
// - external select 1: synchronized external clock divided by eight
// - in split mode the one external select serves both counter bytes
// - per-byte clock selects pick system clock or chosen source per byte
// - auto-reload: reload low byte is loaded into count low byte
// - capture: count low byte is stored in reload low byte
// - auto-reload: reload high byte is loaded into count high byte
// - capture: count high byte is stored in reload high byte
// - count low: low half in 16-bit mode, own counter in split
// - count high: high half in 16-bit mode, own counter in split
// - split bit 0 gives one 16-bit counter, 1 gives two 8-bit
// - capture enabled: falling capture pin edge copies count to reloads
// - 16-bit wrap from FFFF loads both reload bytes and sets high flag; only software clears
// - split mode: run gates high byte only, low byte always counts
module trc_timer (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire trc_pkg::trc_sfr_req_t sfr_req,
    output logic [7:0]              sfr_rdata,
    input  wire trc_pkg::trc_ctrl_t ctrl,
    input  wire trc_pkg::trc_flags_t flag_clear,
    output trc_pkg::trc_flags_t     overflow_flag,
    input  wire logic               ext_clock_pin,
    input  wire logic               capture_input_pin
);
    import trc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge memory

    logic [1:0] ext_sync_r;
    logic [1:0] ext_sync_nxt;
    logic [1:0] cap_sync_r;
    logic [1:0] cap_sync_nxt;
    logic       ext_prev_r;
    logic       ext_prev_nxt;
    logic       cap_prev_r;
    logic       cap_prev_nxt;

    // second stage only is read; first stage feeds nothing else
    always_comb begin
        ext_sync_nxt = {ext_sync_r[0], ext_clock_pin};
        cap_sync_nxt = {cap_sync_r[0], capture_input_pin};
        ext_prev_nxt = ext_sync_r[1];
        cap_prev_nxt = cap_sync_r[1];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ext_sync_r <= 2'b00;
            cap_sync_r <= 2'b11;
            ext_prev_r <= 1'b0;
            cap_prev_r <= 1'b1;
        end else if (ce) begin
            ext_sync_r <= ext_sync_nxt;
            cap_sync_r <= cap_sync_nxt;
            ext_prev_r <= ext_prev_nxt;
            cap_prev_r <= cap_prev_nxt;
        end
    end

    logic ext_rise;
    logic cap_fall;
    assign ext_rise = ext_sync_r[1] & ~ext_prev_r;
    assign cap_fall = ~cap_sync_r[1] & cap_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // prescalers

    logic [DIV_W-1:0] sys_div_r;
    logic [DIV_W-1:0] sys_div_nxt;
    logic [DIV_W-1:0] ext_div_r;
    logic [DIV_W-1:0] ext_div_nxt;
    logic             sys_tick;
    logic             ext_tick;

    always_comb begin
        sys_tick    = (sys_div_r == SYS_DIV_LAST);
        sys_div_nxt = sys_tick ? DIV_ZERO : sys_div_r + 4'h0001;
        ext_tick    = ext_rise && (ext_div_r == EXT_DIV_LAST);
        ext_div_nxt = ext_div_r;
        if (ext_rise) begin
            ext_div_nxt = ext_tick ? DIV_ZERO : ext_div_r + 4'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sys_div_r <= DIV_ZERO;
            ext_div_r <= DIV_ZERO;
        end else if (ce) begin
            sys_div_r <= sys_div_nxt;
            ext_div_r <= ext_div_nxt;
        end
    end

    // one external select serves both bytes; per-byte bit can override
    logic src_tick;
    logic low_tick;
    logic high_tick;
    assign src_tick  = ctrl.external_clock_select ? ext_tick : sys_tick;
    assign low_tick  = ctrl.low_byte_clock_select  ? 1'b1 : src_tick;
    assign high_tick = ctrl.high_byte_clock_select ? 1'b1 : src_tick;

    ////////////////////////////////////////////////////////////////////////
    // counter, reload and flag state

    logic [7:0] count_l_r;
    logic [7:0] count_l_nxt;
    logic [7:0] count_h_r;
    logic [7:0] count_h_nxt;
    logic [7:0] reload_l_r;
    logic [7:0] reload_l_nxt;
    logic [7:0] reload_h_r;
    logic [7:0] reload_h_nxt;
    trc_flags_t flag_r;
    trc_flags_t flag_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    function automatic logic hit(input trc_sfr_req_t r,
                                 input logic [7:0]  a);
        hit = r.wr && (r.addr == a);
    endfunction

    function automatic logic [7:0] inc8(input logic [7:0] v);
        inc8 = v + 8'h0001;
    endfunction

    logic low_go;
    logic high_go;
    logic low_wrap;
    logic high_wrap;
    logic set_low;
    logic set_high;

    always_comb begin
        count_l_nxt  = count_l_r;
        count_h_nxt  = count_h_r;
        reload_l_nxt = reload_l_r;
        reload_h_nxt = reload_h_r;
        low_go       = 1'b0;
        high_go      = 1'b0;
        low_wrap     = (count_l_r == BYTE_MAX);
        high_wrap    = (count_h_r == BYTE_MAX);
        set_low      = 1'b0;
        set_high     = 1'b0;

        if (ctrl.split_mode_enable) begin
            low_go  = low_tick;
            high_go = ctrl.run_control && high_tick;
            if (low_go) begin
                count_l_nxt = low_wrap ? reload_l_r
                                       : inc8(count_l_r);
                set_low     = low_wrap;
            end
            if (high_go) begin
                count_h_nxt = high_wrap ? reload_h_r
                                        : inc8(count_h_r);
                set_high    = high_wrap;
            end
        end else if (ctrl.run_control && low_tick) begin
            // one 16-bit counter clocked by the low-byte source
            count_l_nxt = low_wrap ? (high_wrap ? reload_l_r
                                                : 8'h0000)
                                   : inc8(count_l_r);
            set_low     = low_wrap;
            if (low_wrap) begin
                count_h_nxt = high_wrap ? reload_h_r
                                        : inc8(count_h_r);
                set_high    = high_wrap;
            end
        end

        // capture takes the count as it stands before this edge
        if (ctrl.capture_mode_enable && cap_fall) begin
            reload_l_nxt = count_l_r;
            reload_h_nxt = count_h_r;
        end

        // software writes win over hardware in the same cycle
        if (hit(sfr_req, ADDR_RELOAD_L)) reload_l_nxt = sfr_req.wdata;
        if (hit(sfr_req, ADDR_RELOAD_H)) reload_h_nxt = sfr_req.wdata;
        if (hit(sfr_req, ADDR_COUNT_L))  count_l_nxt  = sfr_req.wdata;
        if (hit(sfr_req, ADDR_COUNT_H))  count_h_nxt  = sfr_req.wdata;

        // hardware set beats a clear arriving together
        flag_nxt.high = set_high | (flag_r.high & ~flag_clear.high);
        flag_nxt.low  = set_low  | (flag_r.low  & ~flag_clear.low);

        unique case (sfr_req.addr)
            ADDR_RELOAD_L: rdata_nxt = reload_l_r;
            ADDR_RELOAD_H: rdata_nxt = reload_h_r;
            ADDR_COUNT_L:  rdata_nxt = count_l_r;
            ADDR_COUNT_H:  rdata_nxt = count_h_r;
            default:       rdata_nxt = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_l_r  <= RST_BYTE;
            count_h_r  <= RST_BYTE;
            reload_l_r <= RST_BYTE;
            reload_h_r <= RST_BYTE;
            flag_r     <= '0;
            rdata_r    <= READ_UNMAPPED;
        end else if (ce) begin
            count_l_r  <= count_l_nxt;
            count_h_r  <= count_h_nxt;
            reload_l_r <= reload_l_nxt;
            reload_h_r <= reload_h_nxt;
            flag_r     <= flag_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    assign sfr_rdata     = rdata_r;
    assign overflow_flag = flag_r;

endmodule

// ---- bench/trc_timer_sva.sv ----
// port assertions for the reload/capture timer
`timescale 1ns/10ps
module trc_timer_sva import trc_pkg::*; (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  ce,
    input wire trc_pkg::trc_sfr_req_t sfr_req,
    input wire logic [7:0]            sfr_rdata,
    input wire trc_pkg::trc_ctrl_t    ctrl,
    input wire trc_pkg::trc_flags_t   flag_clear,
    input wire trc_pkg::trc_flags_t   overflow_flag,
    input wire logic                  ext_clock_pin,
    input wire logic                  capture_input_pin
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    a_reset_clear: assert property (disable iff (1'b0) rst && ce
        |=> overflow_flag == '0 && sfr_rdata == RST_BYTE)
        else $error("reset state wrong");
    a_high_sticky: assert property (
        overflow_flag.high && !flag_clear.high |=> overflow_flag.high)
        else $error("high flag lost");
    a_low_sticky: assert property (
        overflow_flag.low && !flag_clear.low |=> overflow_flag.low)
        else $error("low flag lost");
    a_clear_high: assert property (
        flag_clear.high && ce && !ctrl.run_control |=> !overflow_flag.high)
        else $error("high flag not cleared");
    a_high_needs_run: assert property (
        $rose(overflow_flag.high) |-> $past(ctrl.run_control))
        else $error("high flag set while stopped");
    a_unmapped_zero: assert property (
        ce && (sfr_req.addr < ADDR_RELOAD_L || sfr_req.addr > ADDR_COUNT_H)
        |=> sfr_rdata == READ_UNMAPPED)
        else $error("unmapped read not zero");
    a_ce_freeze: assert property (
        !ce |=> $stable(sfr_rdata) && $stable(overflow_flag))
        else $error("state moved while disabled");
    // sync latency is about three clocks, six stable cycles clears it
    a_ext_quiet: assert property ((ce && ctrl.external_clock_select
        && !ctrl.low_byte_clock_select && !ctrl.high_byte_clock_select
        && $stable(ext_clock_pin))[*6] |=> !$rose(overflow_flag.low))
        else $error("tick without external edge");
endmodule
bind trc_timer trc_timer_sva u_sva (.clk(clk), .rst(rst), .ce(ce),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .ctrl(ctrl),
    .flag_clear(flag_clear), .overflow_flag(overflow_flag),
    .ext_clock_pin(ext_clock_pin), .capture_input_pin(capture_input_pin));

// ---- bench/trc_core_model.sv ----
// processor core model issuing register accesses
`timescale 1ns/10ps
module trc_core_model import trc_pkg::*; (
    input wire logic                  clk,
    output trc_pkg::trc_sfr_req_t     sfr_req,
    input wire logic [7:0]            sfr_rdata
);
    initial sfr_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req <= '{addr: a, wr: 1'b1, wdata: d};
        @(posedge clk);
        sfr_req.wr <= 1'b0;
        // idle edge so a following write never re-raises wr in this step
        @(posedge clk);
    endtask
    // data is registered one edge after the address is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_req <= '{addr: a, wr: 1'b0, wdata: 8'h0000};
        repeat (2) @(posedge clk);
        d = sfr_rdata;
    endtask
endmodule

// ---- bench/trc_timer_test.sv ----
// self-checking bench for the reload/capture timer
`timescale 1ns/10ps
module trc_timer_test import trc_pkg::*;;
    logic         clk = 0, rst = 1, ce = 1, ext_pin = 0, cap_pin = 1;
    trc_ctrl_t    ctrl = '0;
    trc_flags_t   flag_clear = '0, overflow_flag;
    trc_sfr_req_t sfr_req;
    logic [7:0]   sfr_rdata;
    int           fail_count = 0, samples_checked = 0, cycles = 0, n;
    always #5 clk = ~clk;
    trc_core_model core (.clk(clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));
    trc_timer DUT (.clk(clk), .rst(rst), .ce(ce), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .ctrl(ctrl), .flag_clear(flag_clear),
        .overflow_flag(overflow_flag), .ext_clock_pin(ext_pin),
        .capture_input_pin(cap_pin));
    ////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string w, input logic [7:0] e, s);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic rc(input logic [7:0] a, e);
        logic [7:0] d;
        core.rd(a, d);
        chk($sformatf("sfr %h", a), e, d);
    endtask
    // slow pin edges so the synchroniser never misses one
    task automatic pulses(input int k);
        repeat (k) begin
            ext_pin <= 1'b1;
            repeat (2) @(posedge clk);
            ext_pin <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask
    // clocks from a flag clear to the next high overflow
    task automatic gap;
        flag_clear.high <= 1'b1;
        @(posedge clk);
        flag_clear.high <= 1'b0;
        n = 1;
        do begin
            @(posedge clk);
            n++;
        end while (overflow_flag.high !== 1'b1 && n < 100);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) rc(8'(ADDR_RELOAD_L + i), RST_BYTE);
        for (int i = 0; i < 5; i++) core.wr(8'(ADDR_RELOAD_L + i), 8'(49 + i));
        for (int i = 0; i < 5; i++) rc(8'(ADDR_RELOAD_L + i),
            i < 4 ? 8'(49 + i) : READ_UNMAPPED);
        ctrl <= '{split_mode_enable: 1'b1, external_clock_select: 1'b1,
            default: 1'b0};
        core.wr(ADDR_COUNT_L, BYTE_MAX);
        core.wr(ADDR_RELOAD_L, 8'h0040);
        pulses(8);
        rc(ADDR_COUNT_L, 8'h0040);
        chk("low flag", 8'h0001, 8'(overflow_flag.low));
        rc(ADDR_COUNT_H, 8'h0034);
        ctrl.run_control <= 1'b1;
        core.wr(ADDR_COUNT_H, BYTE_MAX);
        pulses(8);
        rc(ADDR_COUNT_H, 8'h0032);
        rc(ADDR_COUNT_L, 8'h0041);
        ctrl.split_mode_enable <= 1'b0;
        flag_clear <= '1;
        core.wr(ADDR_COUNT_L, BYTE_MAX);
        flag_clear <= '0;
        core.wr(ADDR_COUNT_H, BYTE_MAX);
        core.wr(ADDR_RELOAD_H, 8'h0012);
        pulses(8);
        chk("high flag", 8'h0001, 8'(overflow_flag.high));
        rc(ADDR_COUNT_H, 8'h0012);
        pulses(7);
        rc(ADDR_COUNT_L, 8'h0040);
        ctrl.external_clock_select <= 1'b0;
        core.wr(ADDR_RELOAD_L, BYTE_MAX);
        core.wr(ADDR_RELOAD_H, BYTE_MAX);
        core.wr(ADDR_COUNT_H, BYTE_MAX);
        core.wr(ADDR_COUNT_L, BYTE_MAX);
        gap();
        gap();
        chk("tick gap", 8'd12, 8'(n));
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        ctrl <= '{capture_mode_enable: 1'b1, default: 1'b0};
        core.wr(ADDR_COUNT_L, 8'h00cd);
        core.wr(ADDR_COUNT_H, 8'h00ab);
        cap_pin <= 1'b0;
        repeat (6) @(posedge clk);
        cap_pin <= 1'b1;
        repeat (6) @(posedge clk);
        rc(ADDR_RELOAD_L, 8'h00cd);
        rc(ADDR_RELOAD_H, 8'h00ab);
        // per-byte select: low byte ticks every clock, system_clock/12 too slow
        ctrl <= '{split_mode_enable: 1'b1, low_byte_clock_select: 1'b1,
            default: 1'b0};
        flag_clear <= '1;
        @(posedge clk);
        flag_clear <= '0;
        @(posedge clk);
        chk("low flag cleared", 8'h00, 8'(overflow_flag.low));
        repeat (60) @(posedge clk);
        chk("fast low flag", 8'h01, 8'(overflow_flag.low));
        rc(ADDR_COUNT_H, 8'h00ab);
        finish_test();
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            finish_test();
        end
    end
endmodule
